//--- common/wdt_defines.svh
// watchdog constants: register offset, field positions, reset value, timing
// assumes an 8-bit special-function register bus and a crystal-rate tick
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_CTRL_ADDR 8'hc0
`define WDT_CTRL_RESET 8'h10
`define WDT_PRE_RESET 4'h1

`define WDT_PRE_MSB 7
`define WDT_PRE_LSB 4
`define WDT_IRQ_SEL_BIT 3
`define WDT_FLAG_BIT 2
`define WDT_EN_BIT 1
`define WDT_UNLOCK_BIT 0

// base interval is 2^9 crystal cycles; prescale shifts it left
`define WDT_BASE_TICKS 17'h00200
`define WDT_IMMEDIATE_CODE 4'h8
`define WDT_XTAL_HZ 32768
`define WDT_BASE_PERIOD_MS 15.6

`endif

//--- common/wdt_pkg.sv
// watchdog types shared by the design
// assumes wdt_defines.svh for the numeric constants
package wdt_pkg;
   typedef logic [3:0] wdt_pre_t;
   typedef logic [16:0] wdt_count_t;
   typedef enum logic [1:0] {
      WDT_ACT_NONE,
      WDT_ACT_IRQ,
      WDT_ACT_RESET
   } wdt_action_e;
endpackage

//--- rtl/wdt_top.sv
// watchdog timer with a guarded control register at the sfr address
// assumes CRYSTAL_IN is the crystal clock level, already synchronous to
// REF_CLK, and that the core performs one sfr access per strobe
`include "wdt_defines.svh"

module wdt_top
   import wdt_pkg::*;
(
   // clock and external hardware reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // crystal clock level
   input wire logic CRYSTAL_IN,
   // special-function register access from the core
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   // watchdog responses to the system
   output logic WDT_RESET_OUT,
   output logic WDT_IRQ
);

   wdt_pre_t pre_q;
   wdt_pre_t pre_d;
   logic irq_sel_q;
   logic irq_sel_d;
   logic flag_q;
   logic flag_d;
   logic en_q;
   logic en_d;
   logic unlock_q;
   logic unlock_d;
   wdt_count_t count_q;
   wdt_count_t count_d;
   logic xtal_q;
   logic xtal_prev_q;
   logic [7:0] rdata_q;
   logic rst_out_q;
   logic irq_q;

   wire ctrl_hit = (SFR_ADDR == `WDT_CTRL_ADDR);
   wire ctrl_wr = SFR_WR & ctrl_hit;
   // a write is accepted only right after an arming write
   wire wr_ok = ctrl_wr & unlock_q;
   wire arm_wr = ctrl_wr & ~unlock_q & SFR_WDATA[`WDT_UNLOCK_BIT];
   wire [7:0] ctrl_val = {pre_q, irq_sel_q, flag_q, en_q, unlock_q};

   // only rising crystal edges advance the counter, not the core clock
   wire xtal_tick = xtal_q & ~xtal_prev_q;

   // a refresh landing with the expiry tick wins over the timeout
   wire refresh = wr_ok & SFR_WDATA[`WDT_EN_BIT];
   // 17 bits hold the longest interval, 512 shifted left by seven
   wire [16:0] limit = `WDT_BASE_TICKS << pre_q[2:0];
   // reserved codes above 1000b are treated like the immediate code
   wire immediate = pre_q[3];
   wire expired = en_q & xtal_tick & (count_q == limit - 17'h00001);
   wire fire = en_q & ~refresh & (immediate | expired);
   wdt_action_e action;

   assign action = !fire ? WDT_ACT_NONE :
                   (irq_sel_q & ~immediate) ? WDT_ACT_IRQ :
                   WDT_ACT_RESET;

   // prescale restored by a watchdog reset
   wire [3:0] pre_reload = 4'(`WDT_CTRL_RESET >> `WDT_PRE_LSB);

   // next register values
   always_comb begin
      pre_d = pre_q;
      irq_sel_d = irq_sel_q;
      flag_d = flag_q;
      en_d = en_q;
      unlock_d = unlock_q;
      count_d = count_q;
      if (SFR_WR) begin
         // any other sfr write breaks the unlock sequence
         unlock_d = arm_wr;
      end
      if (wr_ok) begin
         pre_d = SFR_WDATA[`WDT_PRE_MSB:`WDT_PRE_LSB];
         irq_sel_d = SFR_WDATA[`WDT_IRQ_SEL_BIT];
         en_d = SFR_WDATA[`WDT_EN_BIT];
         if (!SFR_WDATA[`WDT_FLAG_BIT]) begin
            flag_d = 1'b0;
         end
      end
      if (refresh || !en_q) begin
         count_d = '0;
      end else if (xtal_tick) begin
         count_d = count_q + 17'h00001;
      end
      // flag set wins over a same-cycle software clear
      case (action)
         WDT_ACT_IRQ: begin
            flag_d = 1'b1;
            count_d = '0;
         end
         WDT_ACT_RESET: begin
            // the watchdog reset returns control to defaults but sets
            // the flag so software can tell why it restarted
            pre_d = pre_reload;
            irq_sel_d = 1'b0;
            en_d = 1'b0;
            unlock_d = 1'b0;
            count_d = '0;
            flag_d = 1'b1;
         end
         WDT_ACT_NONE: begin
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         pre_q <= `WDT_PRE_RESET;
      end else begin
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         irq_sel_q <= 1'b0;
      end else begin
         irq_sel_q <= irq_sel_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         unlock_q <= 1'b0;
      end else begin
         unlock_q <= unlock_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // crystal level is already synchronous, one stage finds its edges
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         xtal_q <= 1'b0;
         xtal_prev_q <= 1'b0;
      end else begin
         xtal_q <= CRYSTAL_IN;
         xtal_prev_q <= xtal_q;
      end
   end

   // registered outputs; unmapped reads return zero
   wire [7:0] rdata_d = (SFR_RD & ctrl_hit) ? ctrl_val : 8'h00;
   wire rst_out_d = (action == WDT_ACT_RESET);
   wire irq_d = (action == WDT_ACT_IRQ);

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         rst_out_q <= 1'b0;
      end else begin
         rst_out_q <= rst_out_d;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign SFR_RDATA = rdata_q;
   assign WDT_RESET_OUT = rst_out_q;
   assign WDT_IRQ = irq_q;

endmodule

//--- verif/wdt_top_monitor.sv
// port checker for wdt_top
// assumes a bind from the bench
module wdt_top_monitor (
   // watched ports
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_RDATA,
   input wire logic WDT_RESET_OUT,
   input wire logic WDT_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   logic arm_q, en_q, flg_q;
   wire hit = SFR_WR && SFR_ADDR == 8'hc0;
   wire take = hit && arm_q;
   wire rd = SFR_RD && SFR_ADDR == 8'hc0 && !SFR_WR;
   // shadow of unlock, enable and flag, enough to judge the outputs
   always_ff @(posedge REF_CLK or posedge RESET)
      if (RESET) begin
         arm_q <= 1'b0;
         en_q <= 1'b0;
         flg_q <= 1'b0;
      end else begin
         if (WDT_IRQ || WDT_RESET_OUT) flg_q <= 1'b1;
         else if (take && !SFR_WDATA[2]) flg_q <= 1'b0;
         if (SFR_WR) arm_q <= hit && !arm_q && SFR_WDATA[0];
         if (take) en_q <= SFR_WDATA[1];
         else if (WDT_RESET_OUT) en_q <= 1'b0;
      end
   chk_irq_pulse: assert property (WDT_IRQ |=> !WDT_IRQ)
      else $error("irq too long");
   chk_rst_pulse: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT)
      else $error("reset too long");
   chk_idle_data: assert property (!$past(rd) |-> SFR_RDATA == 8'h00)
      else $error("stray read data");
   chk_off_quiet: assert property
      (!en_q && !$past(en_q) |-> !WDT_IRQ && !WDT_RESET_OUT)
      else $error("action while off");
   chk_immed_reset: assert property
      (take && SFR_WDATA[7] && SFR_WDATA[1] |-> ##[1:3] WDT_RESET_OUT)
      else $error("no immediate reset");
   chk_irq_flag: assert property
      (rd |=> SFR_RDATA[2] == $past(flg_q))
      else $error("flag not set");
   chk_wd_reload: assert property
      (WDT_RESET_OUT ##1 rd |=> SFR_RDATA == 8'h14)
      else $error("bad reload");
   chk_arm_read: assert property
      (hit && !arm_q && SFR_WDATA[0] ##1 rd |=> SFR_RDATA[0])
      else $error("unlock not shown");
   cover property (WDT_IRQ);
   cover property (WDT_RESET_OUT);
   cover property (take);
endmodule

//--- verif/watchdog_timer_block_bench.sv
// hand-written scenarios for wdt_top
// assumes six clocks a crystal period, well above the real rate
module watchdog_timer_block_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = 0, RESET = 1, CRYSTAL_IN = 0, SFR_WR = 0, SFR_RD = 0;
   logic [7:0] SFR_ADDR = 8'hc0, SFR_WDATA = 8'h00, SFR_RDATA;
   logic WDT_RESET_OUT, WDT_IRQ;
   int miscompares = 0, cmp_count = 0, n_irq = 0, n_rst = 0;
   wdt_top DUT (
      .REF_CLK(REF_CLK),
      .RESET(RESET),
      .CRYSTAL_IN(CRYSTAL_IN),
      .SFR_ADDR(SFR_ADDR),
      .SFR_WDATA(SFR_WDATA),
      .SFR_WR(SFR_WR),
      .SFR_RD(SFR_RD),
      .SFR_RDATA(SFR_RDATA),
      .WDT_RESET_OUT(WDT_RESET_OUT),
      .WDT_IRQ(WDT_IRQ)
   );
   always #10 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      if (WDT_IRQ === 1'b1) n_irq++;
      if (WDT_RESET_OUT === 1'b1) n_rst++;
   end
   task automatic chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic wr_at(input logic [7:0] a, d);
      @(posedge REF_CLK) #1;
      SFR_ADDR = a;
      SFR_WR = 1;
      SFR_WDATA = d;
      @(posedge REF_CLK) #1;
      SFR_WR = 0;
      SFR_ADDR = 8'hc0;
   endtask
   task automatic wr(input logic [7:0] d);
      wr_at(8'hc0, d);
   endtask
   task automatic rd_at(input logic [7:0] a, exp);
      @(posedge REF_CLK) #1;
      SFR_ADDR = a;
      SFR_RD = 1;
      @(posedge REF_CLK) #1;
      SFR_RD = 0;
      SFR_ADDR = 8'hc0;
      chk(SFR_RDATA, exp);
   endtask
   task automatic rd(input logic [7:0] exp);
      rd_at(8'hc0, exp);
   endtask
   // n crystal ticks, then the pulse counts since the start
   task automatic run(input int n, input logic [7:0] irq, rst);
      int i0;
      int r0;
      i0 = n_irq;
      r0 = n_rst;
      repeat (2 * n) begin
         repeat (3) @(posedge REF_CLK);
         #1;
         CRYSTAL_IN = ~CRYSTAL_IN;
      end
      repeat (4) @(posedge REF_CLK);
      chk(8'(n_irq - i0), irq);
      chk(8'(n_rst - r0), rst);
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge REF_CLK);
      #1;
      RESET = 0;
      rd(8'h10);
      wr(8'h02);
      rd(8'h10);
      wr(8'h01);
      wr_at(8'h80, 8'h00);
      wr(8'h0a);
      rd(8'h10);
      rd_at(8'h80, 8'h00);
      run(600, 0, 0);
      wr(8'h01);
      rd(8'h11);
      wr(8'h0a);
      run(511, 0, 0);
      wr(8'h01);
      wr(8'h0a);
      run(511, 0, 0);
      run(1, 1, 0);
      rd(8'h0e);
      wr(8'h01);
      wr(8'h12);
      rd(8'h12);
      run(1023, 0, 0);
      run(1, 0, 1);
      rd(8'h14);
      wr(8'h01);
      wr(8'h82);
      run(0, 0, 1);
      #1;
      RESET = 1;
      repeat (2) @(posedge REF_CLK);
      #1;
      RESET = 0;
      rd(8'h10);
      results();
   end
endmodule
bind wdt_top wdt_top_monitor mon (
   .REF_CLK(REF_CLK),
   .RESET(RESET),
   .SFR_ADDR(SFR_ADDR),
   .SFR_WDATA(SFR_WDATA),
   .SFR_WR(SFR_WR),
   .SFR_RD(SFR_RD),
   .SFR_RDATA(SFR_RDATA),
   .WDT_RESET_OUT(WDT_RESET_OUT),
   .WDT_IRQ(WDT_IRQ)
);
